// file: src/eeprom_pkg.sv
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int PAGE_W = 4;
  localparam int BYTE_W = 8;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 2048;

  // ----------------------------------------------------------------
  // Select byte layout
  // ----------------------------------------------------------------
  // Arbitrary type identifier value
  localparam logic [3:0] TYPE_ID = 4'h6;
  localparam int SEL_TYPE_HI = 7;
  localparam int SEL_TYPE_LO = 4;
  localparam int SEL_ADDR_HI = 3;
  localparam int SEL_ADDR_LO = 1;
  localparam int SEL_RW = 0;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int INTERNAL_WRITE_TIME_US = 100;
  localparam int WRITE_CYCLES = (INTERNAL_WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_STOP = 2'b01,
    OP_WRITE = 2'b10,
    OP_READ = 2'b11
  } bus_op_e;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_SEL = 3'b001,
    PH_ADDR = 3'b010,
    PH_WDATA = 3'b011,
    PH_RDATA = 3'b100
  } phase_e;

endpackage

// file: src/eeprom_if.sv
`timescale 1ns/10ps
interface eeprom_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND with pull-up: any driver pulling low wins
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport device (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input sda
  );
endinterface

// file: src/eeprom_device.sv
`timescale 1ns/10ps
module eeprom_device #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic write_protect_in_i,
  output logic busy_o,
  eeprom_if.device bus
);
  import eeprom_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] wp_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_now;
  logic sda_now;
  logic protect;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      wp_sync_q <= 2'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      wp_sync_q <= {wp_sync_q[0], write_protect_in_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end
  assign scl_now = scl_sync_q[1];
  assign sda_now = sda_sync_q[1];
  assign protect = wp_sync_q[1];

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic busy;
  assign scl_rise = scl_now & ~scl_prev_q;
  assign scl_fall = ~scl_now & scl_prev_q;
  assign start_det = ~busy & scl_now & scl_prev_q & sda_prev_q & ~sda_now;
  assign stop_det = ~busy & scl_now & scl_prev_q & ~sda_prev_q & sda_now;

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  phase_e phase_q;
  logic [3:0] bit_cnt_q;
  logic [BYTE_W-1:0] shift_q;
  logic ack_slot_q;
  logic ack_drive_q;
  logic rw_q;
  logic tenth_q;
  logic [ADDR_W-1:0] addr_q;
  logic [BYTE_W-1:0] mem_q [MEM_BYTES];
  logic [BYTE_W-1:0] page_buf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] buf_mask_q;
  logic [31:0] wr_cnt_q;
  logic sda_oe_q;
  logic byte_end;
  logic ack_end;
  logic sel_match;
  logic wdata_take;
  logic load_rd;
  logic wr_start;
  logic commit;
  assign byte_end = ~busy & scl_fall & ~ack_slot_q & (bit_cnt_q == BITS_PER_BYTE)
                    & (phase_q != PH_IDLE);
  assign ack_end = ~busy & scl_fall & ack_slot_q;
  assign sel_match = shift_q[SEL_TYPE_HI:SEL_TYPE_LO] == TYPE_ID;
  assign wdata_take = byte_end & (phase_q == PH_WDATA) & ~protect;
  assign load_rd = ack_end & (((phase_q == PH_SEL) & (rw_q == RW_READ))
                   | (phase_q == PH_RDATA));
  assign wr_start = stop_det & tenth_q & (|buf_mask_q);
  assign busy = wr_cnt_q != 32'h0;
  assign commit = wr_cnt_q == 32'h1;
  assign busy_o = busy;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      phase_q <= PH_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_slot_q <= 1'b0;
      ack_drive_q <= 1'b0;
      rw_q <= 1'b0;
      tenth_q <= 1'b0;
    end else if (busy || stop_det) begin
      // Whole bus ignored until the write cycle ends; a stop means standby
      phase_q <= PH_IDLE;
      ack_slot_q <= 1'b0;
      ack_drive_q <= 1'b0;
      tenth_q <= 1'b0;
    end else if (start_det) begin
      phase_q <= PH_SEL;
      bit_cnt_q <= 4'h0;
      ack_slot_q <= 1'b0;
      ack_drive_q <= 1'b0;
      tenth_q <= 1'b0;
    end else begin
      if (scl_rise) begin
        if (ack_slot_q) begin
          if ((phase_q == PH_RDATA) && sda_now) begin
            phase_q <= PH_IDLE;
            ack_slot_q <= 1'b0;
          end
        end else if (bit_cnt_q < BITS_PER_BYTE) begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (phase_q != PH_RDATA) begin
            shift_q <= {shift_q[BYTE_W-2:0], sda_now};
          end
        end
      end
      if (scl_fall) begin
        tenth_q <= 1'b0;
        if (ack_slot_q) begin
          ack_slot_q <= 1'b0;
          ack_drive_q <= 1'b0;
          bit_cnt_q <= 4'h0;
          unique case (phase_q)
            PH_SEL: begin
              phase_q <= (rw_q == RW_READ) ? PH_RDATA : PH_ADDR;
            end
            PH_ADDR: begin
              phase_q <= PH_WDATA;
            end
            PH_WDATA: begin
              // Marks the slot where a stop commits the page
              tenth_q <= 1'b1;
            end
            PH_RDATA, PH_IDLE: begin
            end
          endcase
          if (load_rd) begin
            shift_q <= mem_q[addr_q];
          end
        end else if (bit_cnt_q == BITS_PER_BYTE) begin
          ack_slot_q <= phase_q != PH_IDLE;
          unique case (phase_q)
            PH_SEL: begin
              if (sel_match) begin
                ack_drive_q <= 1'b1;
                rw_q <= shift_q[SEL_RW];
              end else begin
                phase_q <= PH_IDLE;
                ack_slot_q <= 1'b0;
              end
            end
            PH_ADDR: begin
              ack_drive_q <= 1'b1;
            end
            PH_WDATA: begin
              ack_drive_q <= ~protect;
            end
            PH_RDATA, PH_IDLE: begin
              ack_drive_q <= 1'b0;
            end
          endcase
        end else if (phase_q == PH_RDATA) begin
          // Shift only on falling SCL so SDA never moves while SCL is high
          shift_q <= {shift_q[BYTE_W-2:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Address counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      addr_q <= 11'h000;
    end else if (byte_end && (phase_q == PH_SEL) && sel_match) begin
      addr_q[ADDR_W-1:ADDR_W-3] <= shift_q[SEL_ADDR_HI:SEL_ADDR_LO];
    end else if (byte_end && (phase_q == PH_ADDR)) begin
      addr_q[BYTE_W-1:0] <= shift_q;
    end else if (wdata_take) begin
      // Upper bits held, so the counter wraps to the start of the page
      addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 4'h1;
    end else if (load_rd) begin
      addr_q <= addr_q + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Page buffer and write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      buf_mask_q <= 16'h0000;
    end else if (commit || start_det || (stop_det && !wr_start)) begin
      buf_mask_q <= 16'h0000;
    end else if (wdata_take) begin
      buf_mask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (wdata_take) begin
      // Later bytes at a wrapped offset overwrite earlier ones
      page_buf_q[addr_q[PAGE_W-1:0]] <= shift_q;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wr_cnt_q <= 32'h0;
    end else if (wr_start) begin
      wr_cnt_q <= 32'(WRITE_CYCLES);
    end else if (busy) begin
      wr_cnt_q <= wr_cnt_q - 32'h1;
    end
  end
  // Memory has no reset; contents are undefined until written
  always_ff @(posedge mclk_i) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (buf_mask_q[i]) begin
          mem_q[{addr_q[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_buf_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Open-drain SDA driver
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= ~busy & ((ack_slot_q & ack_drive_q)
                  | ((phase_q == PH_RDATA) & ~ack_slot_q & ~shift_q[BYTE_W-1]));
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe_q;

endmodule

// file: src/eeprom_host.sv
`timescale 1ns/10ps
module eeprom_host #(
  parameter int QUARTER = eeprom_pkg::SCL_QUARTER_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic op_valid_i,
  output logic op_ready_o,
  input eeprom_pkg::bus_op_e op_i,
  input wire logic [7:0] data_i,
  input wire logic ack_i,
  output logic [7:0] data_o,
  output logic ack_o,
  output logic done_o,
  eeprom_if.host bus
);
  import eeprom_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic run_q;
  bus_op_e op_q;
  logic [BYTE_W-1:0] shift_q;
  logic ack_q;
  logic [3:0] bit_q;
  logic [1:0] qtr_q;
  logic [31:0] tick_q;
  logic [1:0] sda_sync_q;
  logic scl_q;
  logic oe_q;
  logic scl_d;
  logic oe_d;
  logic step;
  logic last;

  assign op_ready_o = ~run_q;
  assign step = run_q & (tick_q == 32'(QUARTER - 1));
  assign last = step & (qtr_q == 2'h3)
                & (((op_q == OP_START) | (op_q == OP_STOP)) | (bit_q == BITS_PER_BYTE));

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sda_sync_q <= 2'h3;
    end else begin
      sda_sync_q <= {sda_sync_q[0], bus.sda};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      run_q <= 1'b0;
      op_q <= OP_START;
      shift_q <= 8'h00;
      ack_q <= 1'b0;
      bit_q <= 4'h0;
      qtr_q <= 2'h0;
      tick_q <= 32'h0;
    end else if (!run_q) begin
      if (op_valid_i) begin
        run_q <= 1'b1;
        op_q <= op_i;
        shift_q <= data_i;
        ack_q <= ack_i;
        bit_q <= 4'h0;
        qtr_q <= 2'h0;
        tick_q <= 32'h0;
      end
    end else if (step) begin
      tick_q <= 32'h0;
      qtr_q <= qtr_q + 2'h1;
      if (qtr_q == 2'h2) begin
        if ((op_q == OP_READ) && (bit_q < BITS_PER_BYTE)) begin
          shift_q <= {shift_q[BYTE_W-2:0], sda_sync_q[1]};
        end
      end
      if (qtr_q == 2'h3) begin
        if (last) begin
          run_q <= 1'b0;
        end else begin
          bit_q <= bit_q + 4'h1;
          if (op_q == OP_WRITE) begin
            shift_q <= {shift_q[BYTE_W-2:0], 1'b0};
          end
        end
      end
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      data_o <= 8'h00;
      ack_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= last;
      if (step && (qtr_q == 2'h2) && (op_q == OP_WRITE) && (bit_q == BITS_PER_BYTE)) begin
        ack_o <= ~sda_sync_q[1];
      end
      if (last && (op_q == OP_READ)) begin
        data_o <= shift_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line drive per quarter of a bit
  // ----------------------------------------------------------------
  always_comb begin
    // Lines held between ops; going idle high would add a stray clock
    scl_d = scl_q;
    oe_d = oe_q;
    if (run_q) begin
      unique case (op_q)
        OP_START: begin
          scl_d = (qtr_q == 2'h1) | (qtr_q == 2'h2);
          oe_d = qtr_q[1];
        end
        OP_STOP: begin
          scl_d = qtr_q != 2'h0;
          oe_d = qtr_q[1] == 1'b0;
        end
        OP_WRITE: begin
          // Data set in quarter 0, held while SCL is high
          scl_d = (qtr_q == 2'h1) | (qtr_q == 2'h2);
          oe_d = (bit_q < BITS_PER_BYTE) & ~shift_q[BYTE_W-1];
        end
        OP_READ: begin
          scl_d = (qtr_q == 2'h1) | (qtr_q == 2'h2);
          oe_d = (bit_q == BITS_PER_BYTE) & ack_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      scl_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      scl_q <= scl_d;
      oe_q <= oe_d;
    end
  end

  assign bus.scl = scl_q;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = oe_q;

endmodule

// file: sim/eeprom_assertions.sv
`timescale 1ns/10ps
module eeprom_assertions #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda,
  input wire logic busy_o
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [15:0] busy_cnt_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  // Holds the length of the running write cycle until the fall is seen
  always_ff @(posedge mclk_i) begin
    if (reset_i || !busy_o) begin
      busy_cnt_q <= 16'h0000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Device side of the wire
  // ----------------------------------------------------------------
  open_drain_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data line high");
  oe_rise_low_a: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device pulls data line while clock high");
  oe_fall_low_a: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device releases data line while clock high");
  busy_quiet_a: assert property (busy_o |-> !dev_sda_oe)
    else $error("device drives bus during write cycle");
  busy_len_a: assert property ($fell(busy_o) |->
    int'(busy_cnt_q) >= WRITE_CYCLES - 1 && int'(busy_cnt_q) <= WRITE_CYCLES + 1)
    else $error("write cycle length wrong");
  busy_stop_a: assert property ($rose(busy_o) |-> scl && sda)
    else $error("write cycle started without stop");
  reset_idle_a: assert property ($fell(reset_i) |-> !busy_o && !dev_sda_oe)
    else $error("device not idle after reset");
  stop_release_a: assert property (
    scl && $stable(scl) && $rose(sda) |=> !dev_sda_oe [*8])
    else $error("device drives bus after stop");
endmodule

// file: sim/tb.sv
`timescale 1ns/10ps
module tb;
  import eeprom_pkg::*;
  localparam int QUARTER = 10;
  localparam int WCYC = 1000;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic write_protect_in = 1'b0;
  logic op_valid = 1'b0;
  logic op_ready;
  bus_op_e op_code = OP_START;
  logic [7:0] tx_byte = 8'h00;
  logic tx_ack = 1'b0;
  logic [7:0] rx_byte;
  logic rx_ack;
  logic op_done;
  logic busy;
  logic [7:0] rd;
  logic ak;
  int fail_count = 0;
  int checks = 0;
  int polls;

  always #5 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // Both ends face each other across one bus
  // ----------------------------------------------------------------
  eeprom_if u_eeprom_if ();
  eeprom_host #(.QUARTER(QUARTER)) u_eeprom_host (.mclk_i(mclk_i), .reset_i(reset_i),
    .op_valid_i(op_valid), .op_ready_o(op_ready), .op_i(op_code), .data_i(tx_byte),
    .ack_i(tx_ack), .data_o(rx_byte), .ack_o(rx_ack), .done_o(op_done),
    .bus(u_eeprom_if.host));
  eeprom_device #(.WRITE_CYCLES(WCYC)) u_eeprom_device (.mclk_i(mclk_i), .reset_i(reset_i),
    .write_protect_in_i(write_protect_in), .busy_o(busy), .bus(u_eeprom_if.device));
  eeprom_assertions #(.WRITE_CYCLES(WCYC)) u_eeprom_assertions (.mclk_i(mclk_i),
    .reset_i(reset_i), .scl(u_eeprom_if.scl), .host_sda_o(u_eeprom_if.host_sda_o),
    .host_sda_oe(u_eeprom_if.host_sda_oe), .dev_sda_o(u_eeprom_if.dev_sda_o),
    .dev_sda_oe(u_eeprom_if.dev_sda_oe), .sda(u_eeprom_if.sda), .busy_o(busy));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Entered just after a rising edge; returns at the edge that sees done
  task automatic do_op(input bus_op_e o, input logic [7:0] d, input logic a);
    int n;
    op_valid <= 1'b1;
    op_code <= o;
    tx_byte <= d;
    tx_ack <= a;
    do @(posedge mclk_i); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (op_done !== 1'b1 && n < 2000);
    if (n >= 2000) chk("op done", 8'h01, 8'h00);
    rd = rx_byte;
    ak = rx_ack;
  endtask

  function automatic logic [7:0] sel(input logic [10:0] a, input logic r);
    return {TYPE_ID, a[10:8], r};
  endfunction

  task automatic start_c();
    do_op(OP_START, 8'h00, 1'b0);
    chk("start levels", 8'h00, {6'h00, u_eeprom_if.scl, u_eeprom_if.sda});
  endtask

  task automatic stop_c();
    do_op(OP_STOP, 8'h00, 1'b0);
    chk("stop levels", 8'h03, {6'h00, u_eeprom_if.scl, u_eeprom_if.sda});
  endtask

  task automatic wr(input logic [7:0] d, input logic exp, input string name);
    do_op(OP_WRITE, d, 1'b0);
    chk(name, {7'h00, exp}, {7'h00, ak});
  endtask

  task automatic rdb(input logic a, input logic [7:0] exp, input string name);
    do_op(OP_READ, 8'h00, a);
    chk(name, exp, rd);
  endtask

  task automatic set_addr(input logic [10:0] a);
    start_c();
    wr(sel(a, 1'b0), 1'b1, "write select ack");
    wr(a[7:0], 1'b1, "address ack");
  endtask

  // Repeats start plus write select until the device answers
  task automatic poll(input logic [10:0] a);
    polls = 0;
    start_c();
    do_op(OP_WRITE, sel(a, 1'b0), 1'b0);
    while (ak !== 1'b1 && polls < 20) begin
      polls++;
      start_c();
      do_op(OP_WRITE, sel(a, 1'b0), 1'b0);
    end
    chk("poll ack", 8'h01, {7'h00, ak});
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    set_addr(11'h001);
    wr(8'h3C, 1'b1, "data ack");
    stop_c();
    repeat (10) @(posedge mclk_i);
    chk("busy after stop", 8'h01, {7'h00, busy});
    poll(11'h000);
    chk("busy polls", 8'h01, {7'h00, polls != 0});
    wr(8'h00, 1'b1, "address ack");
    wr(8'hC3, 1'b1, "data ack");
    stop_c();
    poll(11'h000);
    stop_c();
    repeat (20) @(posedge mclk_i);
    chk("busy after select stop", 8'h00, {7'h00, busy});
    start_c();
    wr(sel(11'h000, 1'b1), 1'b1, "read select ack");
    rdb(1'b0, 8'h3C, "current read");
    stop_c();
    write_protect_in <= 1'b1;
    set_addr(11'h000);
    wr(8'h11, 1'b0, "protected data nack");
    stop_c();
    write_protect_in <= 1'b0;
    set_addr(11'h7FE);
    wr(8'hD1, 1'b1, "page data ack");
    wr(8'hD2, 1'b1, "page data ack");
    wr(8'hD3, 1'b1, "page data ack");
    stop_c();
    poll(11'h7FE);
    write_protect_in <= 1'b1;
    wr(8'hFE, 1'b1, "address ack");
    start_c();
    wr(sel(11'h7FE, 1'b1), 1'b1, "read select ack");
    rdb(1'b1, 8'hD1, "sequential 7FE");
    rdb(1'b1, 8'hD2, "sequential 7FF");
    rdb(1'b1, 8'hC3, "rollover to 000");
    rdb(1'b0, 8'h3C, "sequential 001");
    stop_c();
    set_addr(11'h7F0);
    start_c();
    wr(sel(11'h7F0, 1'b1), 1'b1, "read select ack");
    rdb(1'b0, 8'hD3, "page wrap byte");
    stop_c();
    start_c();
    wr({~TYPE_ID, 4'h0}, 1'b0, "foreign type nack");
    stop_c();
    print_verdict();
  end

  // Longest plausible run is well under this span
  initial begin
    #900000;
    fail_count++;
    print_verdict();
  end
endmodule
